/* core/asprb_bank.sv */
`include "asprb_params.svh"
`default_nettype none

module asprb_bank (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_busy,
	input wire logic rx_busy,
	input wire logic tx_taken,
	input wire logic tx_end,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_parity_err,
	input wire logic rx_framing_err,
	input wire logic rx_overrun,
	output logic [7:0] tx_data,
	output logic tx_load,
	output logic soft_reset,
	output logic port_enable,
	output logic [15:0] clock_setting,
	output logic [15:0] mode_setting,
	output logic [15:0] baud_setting,
	output logic irq
);
	// ==========================================================
	// Helpers
	function automatic logic asprb_hit(input logic [31:0] addr, input logic [15:0] idx);
		return (addr[31:18] == 14'h0000) && (addr[17:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	function automatic logic [15:0] asprb_lanes(input logic [3:0] strb);
		return {{8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic [15:0] asprb_merge(input logic [15:0] old,
			input logic [31:0] wd, input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] lane;
		lane = asprb_lanes(strb) & mask;
		return (old & ~lane) | (wd[15:0] & lane);
	endfunction

	// ==========================================================
	// Bus slave
	asprb_reg_if regs ();

	asprb_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.regs(regs)
	);

	// ==========================================================
	// Decoded strobes
	logic wr_clk;
	logic wr_mode;
	logic wr_baud;
	logic wr_ctl;
	logic wr_txd;
	logic wr_flags;
	logic wr_en;
	logic rd_rxd;
	logic [15:0] w1c;

	assign wr_clk = regs.wr && asprb_hit(regs.wr_addr, `ASPRB_IDX_CLOCK_CONTROL);
	assign wr_mode = regs.wr && asprb_hit(regs.wr_addr, `ASPRB_IDX_FRAME_MODE);
	assign wr_baud = regs.wr && asprb_hit(regs.wr_addr, `ASPRB_IDX_BAUD_SETTING);
	assign wr_ctl = regs.wr && asprb_hit(regs.wr_addr, `ASPRB_IDX_CONTROL);
	assign wr_txd = regs.wr && asprb_hit(regs.wr_addr, `ASPRB_IDX_TRANSMIT_BYTE) && regs.wstrb[0];
	assign wr_flags = regs.wr && asprb_hit(regs.wr_addr, `ASPRB_IDX_FLAGS);
	assign wr_en = regs.wr && asprb_hit(regs.wr_addr, `ASPRB_IDX_ENABLES);
	// Read side effects fire only on the cycle the data is sampled
	assign rd_rxd = regs.rd && asprb_hit(regs.rd_addr, `ASPRB_IDX_RECEIVE_BYTE);
	// Only bits with strobed lanes and one written can clear
	assign w1c = wr_flags ? (regs.wdata[15:0] & asprb_lanes(regs.wstrb) & `ASPRB_MASK_FLAGS_W1C)
		: `ASPRB_RST_ZERO;

	// ==========================================================
	// Configuration registers, hard reset only
	logic [7:0] txd;
	logic [15:0] enables;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_setting <= `ASPRB_RST_ZERO;
			mode_setting <= `ASPRB_RST_ZERO;
			baud_setting <= `ASPRB_RST_ZERO;
			enables <= `ASPRB_RST_ZERO;
		end else begin
			if (wr_clk)
				clock_setting <= asprb_merge(clock_setting, regs.wdata, regs.wstrb,
					`ASPRB_MASK_CLOCK_CONTROL);
			if (wr_mode)
				mode_setting <= asprb_merge(mode_setting, regs.wdata, regs.wstrb,
					`ASPRB_MASK_FRAME_MODE);
			if (wr_baud)
				baud_setting <= asprb_merge(baud_setting, regs.wdata, regs.wstrb,
					`ASPRB_MASK_BAUD_SETTING);
			if (wr_en)
				enables <= asprb_merge(enables, regs.wdata, regs.wstrb, `ASPRB_MASK_ENABLES);
		end
	end

	// Control: enable bit held, soft reset a one-cycle self-clearing pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_enable <= 1'b0;
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= wr_ctl && regs.wstrb[0] && regs.wdata[`ASPRB_BIT_SFTRST];
			if (wr_ctl && regs.wstrb[0])
				port_enable <= regs.wdata[`ASPRB_BIT_MODEN];
		end
	end

	// Transmit byte and its load strobe to the engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txd <= `ASPRB_RST_BYTE;
			tx_load <= 1'b0;
		end else begin
			tx_load <= wr_txd;
			if (wr_txd)
				txd <= regs.wdata[7:0];
		end
	end
	assign tx_data = txd;

	// ==========================================================
	// Two-byte receive buffer
	logic [7:0] rx_head;
	logic [7:0] rx_second;
	logic rb1;
	logic rb2;
	logic next_rb1;
	logic next_rb2;
	logic rx_to_head;
	logic rx_to_second;
	logic rx_lost;

	// A read empties the flags first, so a byte in the same cycle is kept
	always_comb begin
		next_rb1 = rd_rxd ? 1'b0 : rb1;
		next_rb2 = rd_rxd ? 1'b0 : rb2;
		rx_to_head = 1'b0;
		rx_to_second = 1'b0;
		rx_lost = 1'b0;
		if (rx_valid) begin
			if (!next_rb1) begin
				next_rb1 = 1'b1;
				rx_to_head = 1'b1;
			end else if (!next_rb2) begin
				next_rb2 = 1'b1;
				rx_to_second = 1'b1;
			end else begin
				rx_lost = 1'b1;
			end
		end
	end

	// Full flags and data are of the soft reset group
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			rb1 <= 1'b0;
			rb2 <= 1'b0;
			rx_head <= `ASPRB_RST_BYTE;
			rx_second <= `ASPRB_RST_BYTE;
		end else begin
			rb1 <= next_rb1;
			rb2 <= next_rb2;
			if (rx_to_head)
				rx_head <= rx_data;
			else if (rd_rxd)
				rx_head <= rx_second;
			if (rx_to_second)
				rx_second <= rx_data;
		end
	end

	// ==========================================================
	// Event flags; a hardware set wins over any bus clear in the same cycle, soft reset wins over both
	logic tbe;
	logic oe;
	logic pe;
	logic fe;
	logic tend;
	logic oe_set;

	assign oe_set = rx_overrun || rx_lost;

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			tend <= 1'b0;
			oe <= 1'b0;
		end else begin
			if (tx_end)
				tend <= 1'b1;
			else if (w1c[`ASPRB_BIT_TEND])
				tend <= 1'b0;
			if (oe_set)
				oe <= 1'b1;
			else if (w1c[`ASPRB_BIT_OE])
				oe <= 1'b0;
		end
	end

	// Error flags clear by write of one or by reading the receive byte
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset) begin
			fe <= 1'b0;
			pe <= 1'b0;
		end else begin
			if (rx_framing_err)
				fe <= 1'b1;
			else if (w1c[`ASPRB_BIT_FE] || rd_rxd)
				fe <= 1'b0;
			if (rx_parity_err)
				pe <= 1'b1;
			else if (w1c[`ASPRB_BIT_PE] || rd_rxd)
				pe <= 1'b0;
		end
	end

	// Buffer empty starts set; the engine taking the byte sets it again
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_reset)
			tbe <= 1'b1;
		else if (tx_taken)
			tbe <= 1'b1;
		else if (wr_txd)
			tbe <= 1'b0;
	end

	// ==========================================================
	// Interrupt and readback
	logic [15:0] flags;

	assign flags = {6'h00, rx_busy, tx_busy, 1'b0, tend, fe, pe, oe, rb2, rb1, tbe};

	// Registered so the output is glitch free; adds one cycle of latency
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(flags[6:0] & enables[6:0]);
	end

	// Write of a read-only register is accepted and ignored
	assign regs.wr_ok = wr_clk || wr_mode || wr_baud || wr_ctl || wr_flags || wr_en
		|| asprb_hit(regs.wr_addr, `ASPRB_IDX_TRANSMIT_BYTE)
		|| asprb_hit(regs.wr_addr, `ASPRB_IDX_RECEIVE_BYTE);

	// Read mux; unmapped addresses answer zero with an error
	always_comb begin
		regs.rd_ok = 1'b1;
		regs.rd_data = `ASPRB_RST_ZERO;
		if (asprb_hit(regs.rd_addr, `ASPRB_IDX_CLOCK_CONTROL))
			regs.rd_data = clock_setting;
		else if (asprb_hit(regs.rd_addr, `ASPRB_IDX_FRAME_MODE))
			regs.rd_data = mode_setting;
		else if (asprb_hit(regs.rd_addr, `ASPRB_IDX_BAUD_SETTING))
			regs.rd_data = baud_setting;
		else if (asprb_hit(regs.rd_addr, `ASPRB_IDX_CONTROL))
			regs.rd_data = {14'h0000, soft_reset, port_enable};
		else if (asprb_hit(regs.rd_addr, `ASPRB_IDX_TRANSMIT_BYTE))
			regs.rd_data = {8'h00, txd};
		else if (asprb_hit(regs.rd_addr, `ASPRB_IDX_RECEIVE_BYTE))
			regs.rd_data = {8'h00, rx_head};
		else if (asprb_hit(regs.rd_addr, `ASPRB_IDX_FLAGS))
			regs.rd_data = flags;
		else if (asprb_hit(regs.rd_addr, `ASPRB_IDX_ENABLES))
			regs.rd_data = enables;
		else
			regs.rd_ok = 1'b0;
	end

	// ==========================================================
	// Checks
	a_tend_w1c_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		w1c[`ASPRB_BIT_TEND] && !tx_end |=> !tend)
		else $error("transmit complete flag not cleared by write of one");

	a_oe_w0_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
		oe && !w1c[`ASPRB_BIT_OE] && !soft_reset |=> oe)
		else $error("overrun flag lost without a write of one");

	a_fe_w1c_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		w1c[`ASPRB_BIT_FE] && !rx_framing_err |=> !fe)
		else $error("framing error flag not cleared by write of one");

	a_pe_w1c_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		w1c[`ASPRB_BIT_PE] && !rx_parity_err |=> !pe)
		else $error("parity error flag not cleared by write of one");

	// The read data is presented in the same cycle the flags clear
	a_rxd_read_errs: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_rxd && !rx_framing_err && !rx_parity_err |=> !fe && !pe && s_axi_rvalid)
		else $error("receive read did not clear error flags");

	a_rxd_read_full: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_rxd && !rx_valid && !soft_reset |=> !rb1 && !rb2 && rx_head == $past(rx_second))
		else $error("receive read did not clear full flags");

	a_tbe_txd_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_txd && !tx_taken && !soft_reset |=> !tbe && tx_load)
		else $error("transmit write did not clear buffer empty");

	a_tbe_reset_one: assert property (@(posedge aclk)
		!aresetn |=> tbe && !irq)
		else $error("buffer empty flag not one after reset");

	a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		|(flags[6:0] & enables[6:0]) |=> irq)
		else $error("interrupt missing for an enabled flag");

	a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		!(|(flags[6:0] & enables[6:0])) |=> !irq)
		else $error("interrupt raised with no enabled flag");
endmodule

`default_nettype wire

/* core/asprb_params.svh */
`ifndef ASPRB_PARAMS_SVH
`define ASPRB_PARAMS_SVH

// ==========================================================
// Register indices; the byte address is four times the index
`define ASPRB_IDX_CLOCK_CONTROL 16'h5200
`define ASPRB_IDX_FRAME_MODE 16'h5202
`define ASPRB_IDX_BAUD_SETTING 16'h5204
`define ASPRB_IDX_CONTROL 16'h5206
`define ASPRB_IDX_TRANSMIT_BYTE 16'h5208
`define ASPRB_IDX_RECEIVE_BYTE 16'h520A
`define ASPRB_IDX_FLAGS 16'h520C
`define ASPRB_IDX_ENABLES 16'h520E

// ==========================================================
// Writable bit masks
`define ASPRB_MASK_CLOCK_CONTROL 16'h0133
`define ASPRB_MASK_FRAME_MODE 16'h037F
`define ASPRB_MASK_BAUD_SETTING 16'h0FFF
`define ASPRB_MASK_ENABLES 16'h007F
`define ASPRB_MASK_FLAGS_W1C 16'h0078

// ==========================================================
// Reset values
`define ASPRB_RST_ZERO 16'h0000
`define ASPRB_RST_BYTE 8'h00

// ==========================================================
// Field positions
`define ASPRB_BIT_TBE 0
`define ASPRB_BIT_RB1 1
`define ASPRB_BIT_RB2 2
`define ASPRB_BIT_OE 3
`define ASPRB_BIT_PE 4
`define ASPRB_BIT_FE 5
`define ASPRB_BIT_TEND 6
`define ASPRB_BIT_TBSY 8
`define ASPRB_BIT_RBSY 9
`define ASPRB_BIT_MODEN 0
`define ASPRB_BIT_SFTRST 1

`endif

/* core/asprb_pkg.sv */
`default_nettype none

package asprb_pkg;
	// ==========================================================
	// Shared types
	typedef logic [15:0] asprb_word_t;
	typedef enum logic [1:0] {
		ASPRB_OKAY = 2'h0,
		ASPRB_SLVERR = 2'h2
	} asprb_resp_t;
endpackage

`default_nettype wire

/* core/asprb_reg_if.sv */
`default_nettype none

// ==========================================================
// Register access strobes between bus slave and bank
interface asprb_reg_if;
	logic wr;
	logic rd;
	logic [31:0] wr_addr;
	logic [31:0] rd_addr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	asprb_pkg::asprb_word_t rd_data;
	logic wr_ok;
	logic rd_ok;
	modport slave(output wr, rd, wr_addr, rd_addr, wdata, wstrb, input rd_data, wr_ok, rd_ok);
	modport bank(input wr, rd, wr_addr, rd_addr, wdata, wstrb, output rd_data, wr_ok, rd_ok);
endinterface

`default_nettype wire

/* core/asprb_axil_slave.sv */
`default_nettype none

// ==========================================================
// AXI4-Lite slave: one write and one read in flight at most
module asprb_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	asprb_reg_if.slave regs
);
	logic aw_held;
	logic w_held;
	logic ar_held;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] araddr_q;

	// A write fires once both halves are in, a read once its address is in; neither while its answer is pending
	assign regs.wr = aw_held && w_held && !bvalid;
	assign regs.rd = ar_held && !rvalid;
	assign regs.wr_addr = awaddr_q;
	assign regs.rd_addr = araddr_q;
	assign regs.wdata = wdata_q;
	assign regs.wstrb = wstrb_q;

	// Write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			awaddr_q <= 32'h0000_0000;
			awready <= 1'b0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			awaddr_q <= awaddr;
			awready <= 1'b0;
		end else if (bvalid && bready) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !bvalid) begin
			awready <= 1'b1;
		end
	end

	// Write data capture, independent of the address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			wready <= 1'b0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
			wready <= 1'b0;
		end else if (bvalid && bready) begin
			w_held <= 1'b0;
		end else if (!w_held && !bvalid) begin
			wready <= 1'b1;
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= asprb_pkg::ASPRB_OKAY;
		end else if (regs.wr) begin
			bvalid <= 1'b1;
			bresp <= regs.wr_ok ? asprb_pkg::ASPRB_OKAY : asprb_pkg::ASPRB_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read channel; data is sampled in the cycle the side effects fire
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_held <= 1'b0;
			araddr_q <= 32'h0000_0000;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= asprb_pkg::ASPRB_OKAY;
		end else begin
			if (arvalid && arready) begin
				ar_held <= 1'b1;
				araddr_q <= araddr;
				arready <= 1'b0;
			end else if (!ar_held && !rvalid) begin
				arready <= 1'b1;
			end
			if (regs.rd) begin
				ar_held <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {16'h0000, regs.rd_data};
				rresp <= regs.rd_ok ? asprb_pkg::ASPRB_OKAY : asprb_pkg::ASPRB_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

/* bench/asprb_bank_tb.sv */
`include "asprb_params.svh"
`default_nettype none

module asprb_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Clock, reset and design stimulus
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic tx_busy = 1'b0, rx_busy = 1'b0;
	// Engine strobes: taken, end, rx byte, parity, framing, overrun
	logic [5:0] ev = 6'h0;
	logic [7:0] rx_data = 8'h0, tx_data;
	// Behavioural model: flags, enables, receive buffer
	logic [31:0] ef, ee, rd, d;
	logic [1:0] rs;
	logic [7:0] rxq[$];
	logic tx_load, soft_reset, port_enable;
	logic [15:0] clock_setting, mode_setting, baud_setting;
	logic [31:0] cfg[4];
	int loads = 0, resets = 0;
	localparam logic [31:0] A_CT = 32'h4 * `ASPRB_IDX_CONTROL;
	int mismatches = 0, check_count = 0;
	localparam logic [31:0] A_TX = 32'h4 * `ASPRB_IDX_TRANSMIT_BYTE;
	localparam logic [31:0] A_RX = 32'h4 * `ASPRB_IDX_RECEIVE_BYTE;
	localparam logic [31:0] A_FL = 32'h4 * `ASPRB_IDX_FLAGS;
	localparam logic [31:0] A_EN = 32'h4 * `ASPRB_IDX_ENABLES;
	logic [31:0] rw_addr[4] = '{32'h4 * `ASPRB_IDX_CLOCK_CONTROL,
		32'h4 * `ASPRB_IDX_FRAME_MODE, 32'h4 * `ASPRB_IDX_BAUD_SETTING, A_EN};
	logic [31:0] rw_mask[4] = '{32'h0133, 32'h037F, 32'h0FFF, 32'h007F};

	// Half-period toggle gives 4 ns
	always #2 aclk = ~aclk;

	// Count one-cycle strobes so a lost or doubled pulse shows up
	always @(posedge aclk) begin
		if (tx_load) loads++;
		if (soft_reset) resets++;
	end

	asprb_bank asprb_bank_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .tx_busy(tx_busy), .rx_busy(rx_busy), .tx_taken(ev[0]),
		.tx_end(ev[1]), .rx_valid(ev[2]), .rx_data(rx_data), .rx_parity_err(ev[3]),
		.rx_framing_err(ev[4]), .rx_overrun(ev[5]), .tx_data(tx_data), .tx_load(tx_load),
		.soft_reset(soft_reset), .port_enable(port_enable), .clock_setting(clock_setting),
		.mode_setting(mode_setting), .baud_setting(baud_setting), .irq(irq)
	);

	// ==========================================================
	// Comparison and verdict
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========================================================
	// Bus master; each wait bounded so a dead slave cannot hang us
	task automatic axi_write(input logic [31:0] a, input logic [31:0] wd, input logic [3:0] s);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready))
			&& n < 50);
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_bvalid && n < 100);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// Let an edge pass so a following call never drives a signal twice at once
		@(posedge aclk);
		if (n >= 100) check(32'h0, 32'h1);
	endtask

	task automatic axi_read(input logic [31:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_arready && n < 50);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_rvalid && n < 100);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		if (n >= 100) check(32'h0, 32'h1);
	endtask

	// Flags read back plus the interrupt level they imply
	task automatic flags_chk();
		axi_read(A_FL);
		check(rd, ef | {22'h0, rx_busy, tx_busy, 8'h0});
		check({31'h0, irq}, {31'h0, |(ef & ee & 32'h7F)});
	endtask

	// One engine strobe cycle, then mirror its effect in the model
	task automatic fire(input logic [5:0] m, input logic [7:0] b);
		ev <= m;
		rx_data <= b;
		@(posedge aclk);
		ev <= 6'h0;
		repeat (2) @(posedge aclk);
		if (m[0]) ef |= 32'h01;
		if (m[1]) ef |= 32'h40;
		if (m[3]) ef |= 32'h10;
		if (m[4]) ef |= 32'h20;
		if (m[5]) ef |= 32'h08;
		if (m[2] && rxq.size() < 2) begin
			rxq.push_back(b);
			ef |= (rxq.size() == 1) ? 32'h02 : 32'h04;
		end else if (m[2]) begin
			ef |= 32'h08;
		end
	endtask

	// ==========================================================
	// Watchdog: whole sequence needs a few hundred cycles
	initial begin
		#100000;
		mismatches++;
		$display("Watchdog expired at %0t", $time);
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(40));
		ef = 32'h1;
		ee = 32'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		flags_chk();
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			axi_write(rw_addr[i], d, 4'hF);
			check({30'h0, rs}, {30'h0, asprb_pkg::ASPRB_OKAY});
			axi_read(rw_addr[i]);
			cfg[i] = d & rw_mask[i];
			check(rd, cfg[i]);
		end
		check({16'h0, clock_setting}, cfg[0]);
		check({16'h0, mode_setting}, cfg[1]);
		check({16'h0, baud_setting}, cfg[2]);
		axi_write(A_EN, 32'h7F, 4'hF);
		ee = 32'h7F;
		// Unmapped address answers with an error and no data
		axi_read(32'h0);
		check({30'h0, rs}, {30'h0, asprb_pkg::ASPRB_SLVERR});
		check(rd, 32'h0);
		axi_write(32'h0, 32'hFFFF, 4'hF);
		check({30'h0, rs}, {30'h0, asprb_pkg::ASPRB_SLVERR});
		{rx_busy, tx_busy} <= 2'($urandom);
		d = $urandom;
		axi_write(A_TX, d, 4'h1);
		ef &= ~32'h01;
		flags_chk();
		check({24'h0, tx_data}, {24'h0, d[7:0]});
		check(32'(loads), 32'h1);
		fire(6'h01, 8'h00);
		flags_chk();
		// Sticky completion and overrun; zero writes must not disturb them
		fire(6'h22, 8'h00);
		axi_write(A_FL, 32'h0, 4'hF);
		flags_chk();
		axi_write(A_FL, 32'h40, 4'hF);
		ef &= ~32'h40;
		flags_chk();
		axi_write(A_FL, 32'h08, 4'hF);
		ef &= ~32'h08;
		flags_chk();
		fire(6'h18, 8'h00);
		axi_write(A_FL, 32'h20, 4'hF);
		ef &= ~32'h20;
		flags_chk();
		axi_write(A_FL, 32'h10, 4'hF);
		ef &= ~32'h10;
		flags_chk();
		// Parity and framing errors, then three bytes; the third overflows
		fire(6'h18, 8'h00);
		for (int i = 0; i < 3; i++) fire(6'h04, 8'($urandom));
		axi_write(A_FL, 32'h06, 4'hF);
		flags_chk();
		axi_read(A_RX);
		check(rd, {24'h0, rxq[0]});
		ef &= ~32'h36;
		rxq.delete();
		flags_chk();
		// Masking gates the interrupt
		axi_write(A_EN, 32'h0, 4'hF);
		ee = 32'h0;
		flags_chk();
		axi_write(A_EN, 32'h08, 4'hF);
		ee = 32'h08;
		flags_chk();
		// Soft reset re-initialises the flags but keeps enables and the enable bit
		axi_write(A_CT, 32'h1, 4'h1);
		axi_write(A_CT, 32'h3, 4'h1);
		ef = 32'h1;
		rxq.delete();
		flags_chk();
		axi_read(A_CT);
		check(rd, 32'h1);
		check({31'h0, port_enable}, 32'h1);
		check(32'(resets), 32'h1);
		wrap_up();
	end
endmodule

`default_nettype wire
